/* verilog/fan_pwm_regs.vh */
// Purpose: constants for the fan speed pwm controller
// Assumes: apb byte addresses, 32-bit data, pclk at 5.5 MHz
// Notes:   tick based delays count pwm period events
`ifndef FAN_PWM_REGS_VH
`define FAN_PWM_REGS_VH

// register byte offsets
`define REG_TEMP          8'h00
`define REG_LIMITS        8'h04
`define REG_CONFIG        8'h08
`define REG_STATUS        8'h0C
`define REG_COMPARE       8'h10

// limits fields
`define LIM_LOWER_LSB     0
`define LIM_LOWER_MSB     7
`define LIM_UPPER_LSB     8
`define LIM_UPPER_MSB     15
`define LIM_OVER_LSB      16
`define LIM_OVER_MSB      23

// config fields, both in period ticks
`define CFG_STALL_LSB     0
`define CFG_STALL_MSB     7
`define CFG_DELAY_LSB     8
`define CFG_DELAY_MSB     15

// reset values
`define TEMP_RST          8'h00
`define LIMITS_RST        24'hE0C040
`define CONFIG_RST        16'h1932

// pwm timer
`define SYS_CLK_HZ        5500000
`define PWM_HZ            50
`define PRESCALE_DIV      2
`define PRESCALE_MAX      1'h1
`define RELOAD            16'hD6D8
`define COUNT_START       16'h0001
`define SCALE_DIV         24'h0000FF

// period tick and one second in ticks
`define TICK_MS           20
`define SECOND_MS         1000
`define TICKS_PER_SEC     6'h32

// duty floor and sweep step, as readings
`define MIN_READING       8'h1A
`define FULL_READING      8'hFF
`define SWEEP_STEP        8'h19

`endif

/* verilog/tach_stall_detector.v */
// Purpose: stall watch for one fan tachometer input
// Assumes: tach_in is asynchronous, tick is one pclk wide
// Notes:   counter restarts on every rising tach edge
`timescale 1ns/1ps
module tach_stall_detector (
   input  wire       pclk,
   input  wire       presetn,
   input  wire       tach_in,
   input  wire       monitor,
   input  wire       tick,
   input  wire [7:0] timeout,
   output wire       stall
);
   reg       meta_q;
   reg       sync_q;
   reg       last_q;
   reg [7:0] cnt_q;
   reg       stall_q;
   wire      rise;

   assign rise  = sync_q & ~last_q;
   assign stall = stall_q;

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_q  <= 1'b0;
         sync_q  <= 1'b0;
         last_q  <= 1'b0;
         cnt_q   <= 8'h00;
         stall_q <= 1'b0;
      end else begin
         meta_q <= tach_in;
         sync_q <= meta_q;
         last_q <= sync_q;
         if (!monitor || rise) begin
            cnt_q <= 8'h00;
         end else if (tick && cnt_q != 8'hFF) begin
            cnt_q <= cnt_q + 8'h01;
         end
         stall_q <= monitor && !rise && (cnt_q >= timeout);
      end
   end
endmodule // tach_stall_detector

/* verilog/fan_speed_pwm_controller.v */
// Purpose: temperature driven pwm for four fans with stall shutdown
// Assumes: apb master on pclk, switches and tach lines asynchronous
// Notes:   reading is written by software into the temp register
//
// Contract
// - one 50 Hz pwm drives all fans
// - timer counts system clock divided by two
// - period reload is 0xD6D8 in two bytes
// - high at start, low on compare, restart 0001H
// - compare is reading times reload over 255
// - minimum duty above lower, proportional, full above upper
// - above upper limit hold full duty
// - period event at every reload match
// - compare refreshed from reading once per second
// - delays are counts of period ticks
// - no tach rise within timeout flags fan
// - any fault switches off every fan
// - fault stays latched until restart
// - overtemp lights indicator, full duty fans
// - sweep switch steps duty 10 to 100 and back
// - fans enabled one by one with delay
// - no pwm below lower limit
// - pwm high, gates low before start
// - sweep ignores temperature reading
`timescale 1ns/1ps
`include "fan_pwm_regs.vh"
module fan_speed_pwm_controller #(parameter [15:0] PERIOD_RELOAD = `RELOAD) (
   input  wire        pclk,
   input  wire        presetn,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [7:0]  paddr,
   input  wire [31:0] pwdata,
   input  wire [3:0]  pstrb,
   output wire [31:0] prdata,
   output wire        pready,
   output wire        pslverr,
   input  wire        restart_switch,
   input  wire        sweep_test_switch,
   input  wire [3:0]  tach_in,
   output wire        pwm_out,
   output wire [3:0]  fan_gate_enable,
   output wire [3:0]  fan_drive,
   output wire [3:0]  fault_indicator,
   output wire        overtemp_indicator
);
   localparam ST_IDLE  = 2'b00;
   localparam ST_START = 2'b01;
   localparam ST_RUN   = 2'b10;
   localparam ST_FAULT = 2'b11;

   // scale a reading onto the reload span
   function [15:0] scale;
      input [7:0] r;
      reg   [23:0] p;
      reg   [23:0] q;
      begin
         p = {16'h0000, r} * {8'h00, PERIOD_RELOAD};
         q = p / `SCALE_DIV;
         scale = q[15:0];
      end
   endfunction

   // merge write data by byte lanes
   function [31:0] merge;
      input [31:0] old;
      input [31:0] wd;
      input [3:0]  strb;
      integer i;
      begin
         merge = old;
         for (i = 0; i < 4; i = i + 1) begin
            if (strb[i]) begin
               merge[i*8 +: 8] = wd[i*8 +: 8];
            end
         end
      end
   endfunction

   reg [7:0]  temp_q;
   reg [23:0] limits_q;
   reg [15:0] config_q;
   reg [31:0] prdata_q;
   reg        pslverr_q;
   reg        rst_meta_q;
   reg        rst_sync_q;
   reg        swp_meta_q;
   reg        swp_sync_q;
   reg [1:0]  state_q;
   reg [3:0]  en_q;
   reg [3:0]  fault_q;
   reg [7:0]  dly_q;
   reg [5:0]  sec_q;
   reg        pre_q;
   reg [15:0] cnt_q;
   reg        pwm_q;
   reg [15:0] active_cmp_q;
   reg [15:0] pending_cmp_q;
   reg [7:0]  sweep_lvl_q;
   reg        sweep_up_q;
   reg        over_q;
   reg [31:0] rd_mux;
   reg        hit;
   reg [15:0] target;
   reg [7:0]  floor_rd;

   wire [7:0] lower;
   wire [7:0] upper;
   wire [7:0] over;
   wire [7:0] stall_to;
   wire [7:0] start_dly;
   wire       setup;
   wire       wr_acc;
   wire       timer_on;
   wire       step;
   wire       tick;
   wire       sec_end;
   wire       demand;
   wire [3:0] stall;
   wire       any_stall;
   wire [31:0] wr_word = merge(rd_mux, pwdata, pstrb);

   assign lower     = limits_q[`LIM_LOWER_MSB:`LIM_LOWER_LSB];
   assign upper     = limits_q[`LIM_UPPER_MSB:`LIM_UPPER_LSB];
   assign over      = limits_q[`LIM_OVER_MSB:`LIM_OVER_LSB];
   assign stall_to  = config_q[`CFG_STALL_MSB:`CFG_STALL_LSB];
   assign start_dly = config_q[`CFG_DELAY_MSB:`CFG_DELAY_LSB];

   // apb slave, zero wait states
   assign setup   = psel & ~penable;
   assign wr_acc  = psel & penable & pwrite;
   assign pready  = 1'b1;
   assign prdata  = prdata_q;
   assign pslverr = pslverr_q & psel & penable;

   always @* begin
      hit    = 1'b1;
      rd_mux = 32'h00000000;
      case (paddr)
         `REG_TEMP:    rd_mux = {24'h000000, temp_q};
         `REG_LIMITS:  rd_mux = {8'h00, limits_q};
         `REG_CONFIG:  rd_mux = {16'h0000, config_q};
         `REG_STATUS:  rd_mux = {16'h0000, sweep_lvl_q, state_q, swp_sync_q, over_q, fault_q};
         `REG_COMPARE: rd_mux = {pending_cmp_q, active_cmp_q};
         default:      hit    = 1'b0;
      endcase
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         temp_q    <= `TEMP_RST;
         limits_q  <= `LIMITS_RST;
         config_q  <= `CONFIG_RST;
         prdata_q  <= 32'h00000000;
         pslverr_q <= 1'b0;
      end else begin
         if (setup) begin
            prdata_q  <= pwrite ? 32'h00000000 : rd_mux;
            pslverr_q <= ~hit;
         end
         if (wr_acc && paddr == `REG_TEMP) begin
            temp_q <= wr_word[7:0];
         end
         if (wr_acc && paddr == `REG_LIMITS) begin
            limits_q <= wr_word[23:0];
         end
         if (wr_acc && paddr == `REG_CONFIG) begin
            config_q <= wr_word[15:0];
         end
      end
   end

   // switch synchronisers
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rst_meta_q <= 1'b0;
         rst_sync_q <= 1'b0;
         swp_meta_q <= 1'b0;
         swp_sync_q <= 1'b0;
      end else begin
         rst_meta_q <= restart_switch;
         rst_sync_q <= rst_meta_q;
         swp_meta_q <= sweep_test_switch;
         swp_sync_q <= swp_meta_q;
      end
   end

   // duty target from reading, limits and sweep
   always @* begin
      floor_rd = (temp_q < `MIN_READING) ? `MIN_READING : temp_q;
      if (swp_sync_q) begin
         target = scale(sweep_lvl_q);
      end else if (temp_q > over) begin
         target = PERIOD_RELOAD;
      end else if (temp_q > upper) begin
         target = PERIOD_RELOAD;
      end else begin
         target = scale(floor_rd);
      end
   end

   // pwm timer, one waveform for all fans
   assign timer_on = (state_q == ST_START) || (state_q == ST_RUN);
   assign step     = (pre_q == `PRESCALE_MAX);
   assign tick     = timer_on && step && (cnt_q == PERIOD_RELOAD);
   assign sec_end  = tick && (sec_q == `TICKS_PER_SEC - 6'h01);

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pre_q        <= 1'b0;
         cnt_q        <= `COUNT_START;
         pwm_q        <= 1'b1;
         active_cmp_q <= PERIOD_RELOAD;
      end else if (!timer_on) begin
         pre_q        <= 1'b0;
         cnt_q        <= `COUNT_START;
         pwm_q        <= 1'b1;
         active_cmp_q <= pending_cmp_q;
      end else begin
         pre_q <= step ? 1'b0 : pre_q + 1'b1;
         if (step) begin
            if (cnt_q == PERIOD_RELOAD) begin
               cnt_q        <= `COUNT_START;
               pwm_q        <= 1'b1;
               active_cmp_q <= pending_cmp_q;
            end else begin
               cnt_q <= cnt_q + 16'h0001;
               if (cnt_q == active_cmp_q) begin
                  pwm_q <= 1'b0;
               end
            end
         end
      end
   end

   // once per second compare refresh and sweep stepping
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sec_q         <= 6'h00;
         pending_cmp_q <= PERIOD_RELOAD;
         sweep_lvl_q   <= `MIN_READING;
         sweep_up_q    <= 1'b1;
      end else begin
         if (!timer_on) begin
            sec_q         <= 6'h00;
            pending_cmp_q <= target;
         end else if (sec_end) begin
            sec_q         <= 6'h00;
            pending_cmp_q <= target;
         end else if (tick) begin
            sec_q <= sec_q + 6'h01;
         end
         if (!swp_sync_q) begin
            sweep_lvl_q <= `MIN_READING;
            sweep_up_q  <= 1'b1;
         end else if (sec_end) begin
            if (sweep_up_q) begin
               if (sweep_lvl_q >= `FULL_READING - `SWEEP_STEP) begin
                  sweep_lvl_q <= `FULL_READING;
                  sweep_up_q  <= 1'b0;
               end else begin
                  sweep_lvl_q <= sweep_lvl_q + `SWEEP_STEP;
               end
            end else begin
               if (sweep_lvl_q <= `MIN_READING + `SWEEP_STEP) begin
                  sweep_lvl_q <= `MIN_READING;
                  sweep_up_q  <= 1'b1;
               end else begin
                  sweep_lvl_q <= sweep_lvl_q - `SWEEP_STEP;
               end
            end
         end
      end
   end

   // tach watch per fan
   genvar g;
   generate
      for (g = 0; g < 4; g = g + 1) begin : tach_watch
         tach_stall_detector u_det (
            .pclk    (pclk),
            .presetn (presetn),
            .tach_in (tach_in[g]),
            .monitor (en_q[g]),
            .tick    (tick),
            .timeout (stall_to),
            .stall   (stall[g])
         );
      end
   endgenerate

   assign any_stall = |stall;
   assign demand    = swp_sync_q || (temp_q > lower) || (temp_q > over);

   // start sequencing and fault latch
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= ST_IDLE;
         en_q    <= 4'h0;
         dly_q   <= 8'h00;
         fault_q <= 4'h0;
         over_q  <= 1'b0;
      end else begin
         over_q <= (temp_q > over);
         if (rst_sync_q) begin
            fault_q <= stall;
         end else begin
            fault_q <= fault_q | stall;
         end
         case (state_q)
            ST_IDLE: begin
               en_q  <= 4'h0;
               dly_q <= 8'h00;
               if (|fault_q || any_stall) begin
                  state_q <= ST_FAULT;
               end else if (demand) begin
                  state_q <= ST_START;
               end
            end
            ST_START: begin
               if (any_stall || |fault_q) begin
                  state_q <= ST_FAULT;
                  en_q    <= 4'h0;
               end else if (!demand) begin
                  state_q <= ST_IDLE;
                  en_q    <= 4'h0;
               end else if (tick) begin
                  if (dly_q + 8'h01 >= start_dly) begin
                     dly_q <= 8'h00;
                     en_q  <= {en_q[2:0], 1'b1};
                     if (en_q[2]) begin
                        state_q <= ST_RUN;
                     end
                  end else begin
                     dly_q <= dly_q + 8'h01;
                  end
               end
            end
            ST_RUN: begin
               if (any_stall || |fault_q) begin
                  state_q <= ST_FAULT;
                  en_q    <= 4'h0;
               end else if (!demand) begin
                  state_q <= ST_IDLE;
                  en_q    <= 4'h0;
               end
            end
            ST_FAULT: begin
               en_q <= 4'h0;
               if (rst_sync_q && !any_stall) begin
                  state_q <= ST_IDLE;
               end
            end
            default: begin
               state_q <= ST_IDLE;
               en_q    <= 4'h0;
            end
         endcase
      end
   end

   assign pwm_out            = pwm_q;
   assign fan_gate_enable    = en_q;
   assign fan_drive          = en_q & {4{pwm_q}};
   assign fault_indicator    = fault_q;
   assign overtemp_indicator = over_q;
endmodule // fan_speed_pwm_controller

/* bench/fan_pwm_checker_sva.sv */
// Purpose: port level assertions for the fan pwm controller
// Assumes: zero wait apb, reload handed in through the bind
// Notes:   bound to the top module
`timescale 1ns/1ps
module fan_pwm_checker #(parameter logic [15:0] PERIOD_RELOAD = 16'hD6D8) (
   input logic       pclk,
   input logic       presetn,
   input logic       psel,
   input logic       penable,
   input logic [7:0] paddr,
   input logic       pslverr,
   input logic       restart_switch,
   input logic       pwm_out,
   input logic [3:0] fan_gate_enable,
   input logic [3:0] fan_drive,
   input logic [3:0] fault_indicator
);
   logic [16:0] per_q;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_acc;
      psel && penable;
   endsequence
   sequence s_quiet;
      !restart_switch [*4] ##0 |fault_indicator;
   endsequence
   // cycles since the last rising pwm edge
   always @(posedge pclk or negedge presetn) begin
      if (!presetn)
         per_q <= 17'h00000;
      else if ($rose(pwm_out))
         per_q <= 17'h00000;
      else if (per_q != 17'h1FFFF)
         per_q <= per_q + 17'h00001;
   end
   chk_err_map: assert property (s_acc ##0 (paddr > 8'h10) |-> pslverr)
      else $error("unmapped access without error");
   chk_drive_gate: assert property (fan_drive == (fan_gate_enable & {4{pwm_out}}))
      else $error("fan drive not gated pwm");
   chk_gate_order: assert property (fan_gate_enable inside {4'h0, 4'h1, 4'h3, 4'h7, 4'hF})
      else $error("fans enabled out of order");
   chk_gate_single: assert property (($changed(fan_gate_enable) && |fan_gate_enable)
      |-> $countones(fan_gate_enable ^ $past(fan_gate_enable)) == 1)
      else $error("two fans switched at once");
   chk_fault_off: assert property (|fault_indicator ##1 |fault_indicator
      |-> fan_gate_enable == 4'h0 && pwm_out)
      else $error("fans running with a fault");
   chk_fault_latch: assert property (s_quiet |=> |fault_indicator)
      else $error("fault cleared without restart");
   chk_pwm_period: assert property (($rose(pwm_out) && |fan_gate_enable
      && $past(|fan_gate_enable)) |-> per_q + 17'h00001 == {PERIOD_RELOAD, 1'b0})
      else $error("pwm period length wrong");
   chk_pwm_start: assert property ($rose(pwm_out) && |fan_gate_enable |=> pwm_out [*8])
      else $error("pwm period not starting high");
endmodule // fan_pwm_checker

bind fan_speed_pwm_controller fan_pwm_checker #(.PERIOD_RELOAD(PERIOD_RELOAD)) i_chk (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr),
   .pslverr(pslverr), .restart_switch(restart_switch), .pwm_out(pwm_out),
   .fan_gate_enable(fan_gate_enable), .fan_drive(fan_drive),
   .fault_indicator(fault_indicator)
);

/* bench/fan_bank_model.sv */
// Purpose: four fans whose tach toggles while gated on
// Assumes: jam holds a stopped fan's tach steady
// Notes:   tach period 2048 clocks
`timescale 1ns/1ps
module fan_bank_model (
   input  logic       pclk,
   input  logic       presetn,
   input  logic [3:0] gate_on,
   input  logic [3:0] jam,
   output logic [3:0] tach
);
   logic [9:0] div_q;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_q <= 10'h000;
         tach <= 4'h0;
      end else begin
         div_q <= div_q + 10'h001;
         if (div_q == 10'h3FF)
            tach <= tach ^ (gate_on & ~jam);
      end
   end
endmodule // fan_bank_model

/* bench/fan_speed_pwm_controller_bench.sv */
// Purpose: self checking bench for the fan speed pwm controller
// Assumes: short stall and start delay programmed through config
// Notes:   short reload override gives 512 clock periods, run near 35000 clocks
`timescale 1ns/1ps
`include "fan_pwm_regs.vh"
module fan_speed_pwm_controller_bench;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
   logic        restart_switch, sweep_test_switch, pwm_out, overtemp_indicator;
   logic [7:0]  paddr, temp;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0]  pstrb, tach_in, fan_gate_enable, fan_drive, fault_indicator, jam;
   logic [7:0]  tv [4] = '{8'h05, 8'h33, 8'hC5, 8'hF0};
   int          n_errors, total_checks, cyc, t0, hi;

   // short reload so ticks and seconds fit the run
   localparam logic [15:0] RL = 16'h0100;

   fan_speed_pwm_controller #(.PERIOD_RELOAD(RL)) i_dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .restart_switch(restart_switch),
      .sweep_test_switch(sweep_test_switch), .tach_in(tach_in), .pwm_out(pwm_out),
      .fan_gate_enable(fan_gate_enable), .fan_drive(fan_drive),
      .fault_indicator(fault_indicator), .overtemp_indicator(overtemp_indicator)
   );
   fan_bank_model i_fans (
      .pclk(pclk), .presetn(presetn), .gate_on(fan_gate_enable), .jam(jam), .tach(tach_in)
   );

   task automatic give_verdict;
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         n_errors++;
         $display("unexpected %s: expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic near(input string nm, input int e, input int g);
      total_checks++;
      if (g > e + 4 || g + 4 < e) begin
         n_errors++;
         $display("unexpected %s: expected %0d seen %0d", nm, e, g);
      end
   endtask

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] m, e);
      apb(1'b0, a, 32'h0, 4'h0);
      chk(nm, e, rd & m);
   endtask

   task automatic wait_gate(input int k);
      while (fan_gate_enable[k] !== 1'b1) @(posedge pclk);
   endtask

   task automatic wait_pwm(input logic v);
      while (pwm_out !== v) @(posedge pclk);
   endtask

   function automatic logic [15:0] exp_cmp(input logic [7:0] t);
      logic [31:0] p;
      p = (t < `MIN_READING ? `MIN_READING : t) * RL / `FULL_READING;
      return (t > 8'hC0) ? RL : p[15:0];
   endfunction

   initial pclk = 1'b0;
   always #10 pclk = ~pclk;

   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 32'h0000EA60) begin
         n_errors++;
         give_verdict();
      end
   end

   initial begin
      presetn = 1'b0;
      {psel, penable, pwrite, restart_switch, sweep_test_switch} = 5'h00;
      paddr = 8'h00;
      pwdata = 32'h0;
      pstrb = 4'h0;
      jam = 4'h0;
      void'($urandom(32'h62ED8BFB));
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rchk("temp", `REG_TEMP, 32'hFFFFFFFF, {24'h0, `TEMP_RST});
      rchk("limits", `REG_LIMITS, 32'hFFFFFFFF, {8'h0, `LIMITS_RST});
      rchk("config", `REG_CONFIG, 32'hFFFFFFFF, {16'h0, `CONFIG_RST});
      rchk("unmapped", 8'h40, 32'hFFFFFFFF, 32'h0);
      chk("slverr", 32'h1, er);
      chk("idle pins", 32'h100, {pwm_out, fan_gate_enable, fan_drive});
      $display("test reset done");
      temp = 8'h41 + 8'($urandom % 32'h7F);
      apb(1'b1, `REG_LIMITS, 32'hFFFFFFFF, 4'h1);
      rchk("limits lane", `REG_LIMITS, 32'hFFFFFFFF, 32'h00E0C0FF);
      apb(1'b1, `REG_CONFIG, 32'h00000108, 4'hF);
      apb(1'b1, `REG_TEMP, {24'h0, temp}, 4'hF);
      chk("no demand", 32'h100, {pwm_out, fan_gate_enable, fan_drive});
      apb(1'b1, `REG_LIMITS, 32'h00000040, 4'h1);
      wait_gate(0);
      t0 = cyc;
      for (int k = 1; k < 4; k++) begin
         wait_gate(k);
         chk("gate spacing", 32'h2 * RL, cyc - t0);
         chk("gate order", (32'h2 << k) - 32'h1, fan_gate_enable);
         t0 = cyc;
      end
      wait_pwm(1'b0);
      wait_pwm(1'b1);
      t0 = cyc;
      wait_pwm(1'b0);
      hi = cyc - t0;
      wait_pwm(1'b1);
      chk("period", 32'h2 * RL, cyc - t0);
      near("high time", 2 * exp_cmp(temp), hi);
      rchk("compare", `REG_COMPARE, 32'hFFFFFFFF, {2{exp_cmp(temp)}});
      rchk("state run", `REG_STATUS, 32'hC0, 32'h80);
      $display("test ramp done");
      jam <= 4'h4;
      t0 = cyc;
      while (fault_indicator === 4'h0) @(posedge pclk);
      chk("stall time", 32'h1, cyc - t0 > 32'hE * RL - 32'h800 && cyc - t0 < 32'h10 * RL + 32'h10);
      repeat (4) @(posedge pclk);
      chk("fault", 32'h4, fault_indicator);
      chk("all off", 32'h100, {pwm_out, fan_gate_enable, fan_drive});
      for (int i = 0; i < 4; i++) begin
         apb(1'b1, `REG_TEMP, {24'h0, tv[i]}, 4'hF);
         repeat (4) @(posedge pclk);
         rchk("pending", `REG_COMPARE, 32'hFFFF0000, {exp_cmp(tv[i]), 16'h0});
         chk("overtemp", tv[i] > 8'hE0, overtemp_indicator);
      end
      rchk("fault state", `REG_STATUS, 32'hCF, 32'hC4);
      apb(1'b1, `REG_TEMP, 32'h0, 4'hF);
      restart_switch <= 1'b1;
      repeat (8) @(posedge pclk);
      restart_switch <= 1'b0;
      jam <= 4'h0;
      repeat (4) @(posedge pclk);
      chk("cleared", 32'h0, fault_indicator);
      $display("test stall done");
      sweep_test_switch <= 1'b1;
      repeat (6) @(posedge pclk);
      rchk("sweep", `REG_STATUS, 32'hE0, 32'h60);
      repeat (32'h66 * RL) @(posedge pclk);
      rchk("sweep step", `REG_STATUS, 32'hFFE0, 32'h33A0);
      rchk("sweep duty", `REG_COMPARE, 32'hFFFFFFFF, {2{exp_cmp(`MIN_READING)}});
      sweep_test_switch <= 1'b0;
      repeat (6) @(posedge pclk);
      rchk("idle", `REG_STATUS, 32'hE0, 32'h00);
      chk("idle pins", 32'h100, {pwm_out, fan_gate_enable, fan_drive});
      $display("test sweep done");
      give_verdict();
   end
endmodule // fan_speed_pwm_controller_bench
